// ### src/dbc_pkg.sv
// shared types and constants for the branch and call unit
`default_nettype none
package dbc_pkg;
    localparam int          PC_W       = 16;
    localparam int          DATA_W     = 16;
    localparam int          ACC_W      = 32;
    localparam int          AUX_N      = 8;
    localparam int          AUX_PTR_W  = 3;
    localparam int          CNT_W      = 8;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [15:0] STEP_ONE   = 16'h0001;
    localparam logic [15:0] STEP_TWO   = 16'h0002;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_BR_ALWAYS,
        OP_BR_TO_ACC,
        OP_BR_AUX_NZ,
        OP_BR_TC_SET,
        OP_BR_TC_CLR,
        OP_BR_CARRY,
        OP_BR_NO_CARRY,
        OP_BR_ACC_GE,
        OP_BR_ACC_GT,
        OP_BR_ACC_LE,
        OP_BR_ACC_LT,
        OP_BR_ACC_EQ,
        OP_BR_ACC_NE,
        OP_BR_INPUT_LOW,
        OP_BR_NO_OVF,
        OP_BR_ON_OVF,
        OP_CALL_DIRECT,
        OP_CALL_INDIRECT,
        OP_RETURN,
        OP_MOVE_DATA,
        OP_MOVE_PROG
    } dbc_op_t;

    typedef struct packed {
        dbc_op_t            op;
        logic [PC_W-1:0]    operand;
        logic [DATA_W-1:0]  dst;
        logic [CNT_W-1:0]   count;
    } dbc_cmd_t;

    typedef struct packed {
        logic tc;
        logic carry;
        logic ovf;
    } dbc_flags_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_CAPTURE
    } dbc_state_t;
endpackage
`default_nettype wire

// ### src/dbc_cond_eval.sv
// branch condition evaluator for conditional two-word branches
`default_nettype none
module dbc_cond_eval
    import dbc_pkg::*;
(
    input  wire dbc_op_t            op,
    input  wire logic [ACC_W-1:0]   acc,
    input  wire dbc_flags_t         flags,
    input  wire logic [DATA_W-1:0]  aux_sel,
    input  wire logic               pin_level,
    output logic                    taken
);
    wire logic acc_neg  = acc[ACC_W-1];
    wire logic acc_zero = (acc == '0);

    always_comb begin
        case (op)
            OP_BR_ALWAYS:    taken = 1'b1;
            OP_BR_AUX_NZ:    taken = (aux_sel != '0);
            OP_BR_TC_SET:    taken = flags.tc;
            OP_BR_TC_CLR:    taken = !flags.tc;
            OP_BR_CARRY:     taken = flags.carry;
            OP_BR_NO_CARRY:  taken = !flags.carry;
            OP_BR_ACC_GE:    taken = !acc_neg;
            OP_BR_ACC_GT:    taken = !acc_neg && !acc_zero;
            OP_BR_ACC_LE:    taken = acc_neg || acc_zero;
            OP_BR_ACC_LT:    taken = acc_neg;
            OP_BR_ACC_EQ:    taken = acc_zero;
            OP_BR_ACC_NE:    taken = !acc_zero;
            OP_BR_INPUT_LOW: taken = !pin_level;
            OP_BR_NO_OVF:    taken = !flags.ovf;
            OP_BR_ON_OVF:    taken = flags.ovf;
            default:         taken = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### src/dbc_branch_call_unit.sv
// program-flow unit: branches, calls, returns and block moves
// Function
// - accumulator branch loads pc from low sixteen accumulator bits
// - aux branch jumps if selected aux register nonzero, else pc plus two
// - test-set branch jumps when test flag is one, else pc plus two
// - test-clear branch jumps when test flag is zero, else pc plus two
// - carry branch jumps when carry is one, else pc plus two
// - no-carry branch jumps when carry is zero, else pc plus two
// - jump when accumulator is >= 0 or > 0, else pc plus two
// - jump when accumulator is <= 0 or < 0, else pc plus two
// - jump when accumulator is zero or nonzero, else pc plus two
// - input-pin branch jumps when sampled pin is low, else pc plus two
// - no-overflow branch jumps when overflow flag is clear, else plus two
// - data block move copies from operand address to destination
// - program block move reads program memory, writes data memory
`default_nettype none
module dbc_branch_call_unit
    import dbc_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic                     cmd_valid,
    input  wire dbc_cmd_t                 cmd,
    output logic                          cmd_ready_q,
    input  wire logic [ACC_W-1:0]         acc,
    input  wire dbc_flags_t               flags,
    input  wire logic [AUX_N*DATA_W-1:0]  aux_regs,
    input  wire logic [AUX_PTR_W-1:0]     aux_register_pointer,
    input  wire logic                     branch_input_pin,
    input  wire logic [PC_W-1:0]          stack_top,
    output logic [PC_W-1:0]               pc_q,
    output logic                          stack_push_q,
    output logic [PC_W-1:0]               stack_push_data_q,
    output logic                          stack_pop_q,
    output logic                          mem_rd_q,
    output logic                          mem_rd_prog_q,
    output logic [PC_W-1:0]               mem_rd_addr_q,
    input  wire logic [DATA_W-1:0]        mem_rd_data,
    output logic                          mem_wr_q,
    output logic [DATA_W-1:0]             mem_wr_addr_q,
    output logic [DATA_W-1:0]             mem_wr_data_q,
    output logic                          done_q
);
    // pin synchroniser: level changes once stages two and three agree
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic pin_lvl_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_q  <= 1'b1;
            pin_s2_q  <= 1'b1;
            pin_s3_q  <= 1'b1;
            pin_lvl_q <= 1'b1;
        end else begin
            pin_s1_q <= branch_input_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) begin
                pin_lvl_q <= pin_s3_q;
            end
        end
    end

    wire logic              accept   = cmd_valid && cmd_ready_q;
    wire logic [DATA_W-1:0] aux_sel  =
        aux_regs[aux_register_pointer*DATA_W +: DATA_W];
    wire logic [PC_W-1:0]   pc_inc1  = pc_q + STEP_ONE;
    wire logic [PC_W-1:0]   pc_inc2  = pc_q + STEP_TWO;
    wire logic [PC_W-1:0]   acc_low  = acc[PC_W-1:0];
    wire logic              is_move  = (cmd.op == OP_MOVE_DATA) ||
                                       (cmd.op == OP_MOVE_PROG);
    wire logic              cond_taken;

    dbc_cond_eval u_cond (
        .op        (cmd.op),
        .acc       (acc),
        .flags     (flags),
        .aux_sel   (aux_sel),
        .pin_level (pin_lvl_q),
        .taken     (cond_taken)
    );

    // next pc for single-step instructions
    logic [PC_W-1:0] pc_next;
    always_comb begin
        case (cmd.op)
            OP_NOP:           pc_next = pc_inc1;
            OP_BR_TO_ACC:     pc_next = acc_low;
            OP_CALL_INDIRECT: pc_next = acc_low;
            OP_CALL_DIRECT:   pc_next = cmd.operand;
            OP_RETURN:        pc_next = stack_top;
            default:          pc_next = cond_taken ? cmd.operand : pc_inc2;
        endcase
    end

    dbc_state_t        state_q;
    logic [CNT_W-1:0]  left_q;
    logic [PC_W-1:0]   src_q;
    logic [DATA_W-1:0] dst_q;
    wire logic         last_word = (left_q == '0);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q           <= ST_IDLE;
            cmd_ready_q       <= 1'b1;
            pc_q              <= PC_RESET;
            stack_push_q      <= 1'b0;
            stack_push_data_q <= '0;
            stack_pop_q       <= 1'b0;
            mem_rd_q          <= 1'b0;
            mem_rd_prog_q     <= 1'b0;
            mem_rd_addr_q     <= '0;
            mem_wr_q          <= 1'b0;
            mem_wr_addr_q     <= '0;
            mem_wr_data_q     <= '0;
            done_q            <= 1'b0;
            left_q            <= '0;
            src_q             <= '0;
            dst_q             <= '0;
        end else begin
            stack_push_q <= 1'b0;
            stack_pop_q  <= 1'b0;
            mem_rd_q     <= 1'b0;
            mem_wr_q     <= 1'b0;
            done_q       <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (accept && is_move) begin
                        // source address comes from the command operand
                        state_q       <= ST_READ;
                        cmd_ready_q   <= 1'b0;
                        mem_rd_q      <= 1'b1;
                        mem_rd_prog_q <= (cmd.op == OP_MOVE_PROG);
                        mem_rd_addr_q <= cmd.operand;
                        src_q         <= cmd.operand + STEP_ONE;
                        dst_q         <= cmd.dst;
                        left_q        <= cmd.count;
                    end else if (accept) begin
                        pc_q   <= pc_next;
                        done_q <= 1'b1;
                        if (cmd.op == OP_CALL_DIRECT) begin
                            stack_push_q      <= 1'b1;
                            stack_push_data_q <= pc_inc2;
                        end else if (cmd.op == OP_CALL_INDIRECT) begin
                            stack_push_q      <= 1'b1;
                            stack_push_data_q <= pc_inc1;
                        end else if (cmd.op == OP_RETURN) begin
                            stack_pop_q <= 1'b1;
                        end
                    end
                end
                ST_READ: begin
                    state_q <= ST_CAPTURE;
                end
                ST_CAPTURE: begin
                    // read data is valid one cycle after the read strobe
                    mem_wr_q      <= 1'b1;
                    mem_wr_addr_q <= dst_q;
                    mem_wr_data_q <= mem_rd_data;
                    dst_q         <= dst_q + STEP_ONE;
                    if (last_word) begin
                        state_q     <= ST_IDLE;
                        cmd_ready_q <= 1'b1;
                        pc_q        <= pc_inc2;
                        done_q      <= 1'b1;
                    end else begin
                        state_q       <= ST_READ;
                        mem_rd_q      <= 1'b1;
                        mem_rd_addr_q <= src_q;
                        src_q         <= src_q + STEP_ONE;
                        left_q        <= left_q - 1'b1;
                    end
                end
                default: begin
                    state_q     <= ST_IDLE;
                    cmd_ready_q <= 1'b1;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic single_ok;
    assign single_ok = accept && !is_move;

    AST_BR_TO_ACC: assert property (
        single_ok && cmd.op == OP_BR_TO_ACC |=> pc_q == $past(acc_low)
    ) else $error("accumulator branch pc mismatch");

    AST_AUX_NZ: assert property (
        single_ok && cmd.op == OP_BR_AUX_NZ |=>
        pc_q == (($past(aux_sel) != '0) ? $past(cmd.operand)
                                        : $past(pc_q) + STEP_TWO)
    ) else $error("aux branch pc mismatch");

    AST_TC_SET: assert property (
        single_ok && cmd.op == OP_BR_TC_SET && !flags.tc |=>
        pc_q == $past(pc_q) + STEP_TWO
    ) else $error("test-set branch taken with flag clear");

    AST_CARRY: assert property (
        single_ok && cmd.op == OP_BR_CARRY && flags.carry |=>
        pc_q == $past(cmd.operand)
    ) else $error("carry branch not taken");

    AST_ACC_LT: assert property (
        single_ok && cmd.op == OP_BR_ACC_LT && !acc[ACC_W-1] |=>
        pc_q == $past(pc_q) + STEP_TWO
    ) else $error("less-than branch taken on non-negative");

    AST_NO_OVF: assert property (
        single_ok && cmd.op == OP_BR_NO_OVF && !flags.ovf |=>
        pc_q == $past(cmd.operand)
    ) else $error("no-overflow branch not taken");

    AST_CALL: assert property (
        single_ok && cmd.op == OP_CALL_DIRECT |=>
        stack_push_q && stack_push_data_q == $past(pc_q) + STEP_TWO
        && pc_q == $past(cmd.operand)
    ) else $error("direct call push or target wrong");

    AST_CALL_INDIRECT: assert property (
        single_ok && cmd.op == OP_CALL_INDIRECT |=>
        stack_push_q && stack_push_data_q == $past(pc_q) + STEP_ONE
    ) else $error("indirect call push wrong");

    AST_RET: assert property (
        single_ok && cmd.op == OP_RETURN |=>
        stack_pop_q && pc_q == $past(stack_top)
    ) else $error("return did not restore pc");

    AST_MOVE_ONE: assert property (
        accept && is_move && cmd.count == '0 |=>
        mem_rd_q && mem_rd_addr_q == $past(cmd.operand) ##2
        mem_wr_q && done_q && mem_wr_addr_q == $past(cmd.dst, 3)
    ) else $error("single word move sequence wrong");

    AST_MOVE_PROG: assert property (
        accept && cmd.op == OP_MOVE_PROG |=> mem_rd_prog_q
    ) else $error("program move did not read program memory");

    CV_CALL: cover property (single_ok && cmd.op == OP_CALL_DIRECT);
    CV_RET:  cover property (single_ok && cmd.op == OP_RETURN);
    CV_MOVE: cover property (accept && is_move && cmd.count != '0);
    CV_PIN:  cover property (single_ok && cmd.op == OP_BR_INPUT_LOW
                             && !pin_lvl_q);
endmodule
`default_nettype wire

// ### sim/dbc_mem_model.sv
// program and data memory model answering block-move reads
`default_nettype none
module dbc_mem_model
    import dbc_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               mem_rd_q,
    input  wire logic               mem_rd_prog_q,
    input  wire logic [PC_W-1:0]    mem_rd_addr_q,
    output logic      [DATA_W-1:0]  mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // valid only the cycle after the strobe, toggling garbage otherwise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_rd_data <= 16'ha5a5;
        end else if (mem_rd_q) begin
            mem_rd_data <= mem_rd_prog_q ? (mem_rd_addr_q ^ 16'hc3c3)
                                         : (mem_rd_addr_q + 16'h7000);
        end else begin
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule
`default_nettype wire

// ### sim/test_dbc_branch_call_unit.sv
// self-checking bench for the branch and call unit
`default_nettype none
module test_dbc_branch_call_unit
    import dbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    ref_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    cmd_valid = 1'b0;
    dbc_cmd_t                cmd = '0;
    logic [ACC_W-1:0]        acc = '0;
    dbc_flags_t              flags = '0;
    logic [AUX_N*DATA_W-1:0] aux = '0;
    logic [AUX_PTR_W-1:0]    ptr = '0;
    logic                    pin = 1'b1;
    logic [PC_W-1:0]         stk = '0;
    logic                    ready, push, pop, rd, rd_prog, wr, done;
    logic [PC_W-1:0]         pc, push_data, rd_addr;
    logic [DATA_W-1:0]       rd_data, wr_addr, wr_data;
    logic [15:0]             epc = PC_RESET;
    logic [15:0]             src, dst, n_rd, n_wr, cycles;
    logic                    prog = 1'b0;
    int                      n_errors = 0;
    int                      check_count = 0;
    int                      tick = 0;

    always #20 ref_clk = ~ref_clk;

    dbc_branch_call_unit DUT (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready_q(ready), .acc(acc), .flags(flags), .aux_regs(aux),
        .aux_register_pointer(ptr), .branch_input_pin(pin),
        .stack_top(stk), .pc_q(pc), .stack_push_q(push),
        .stack_push_data_q(push_data), .stack_pop_q(pop),
        .mem_rd_q(rd), .mem_rd_prog_q(rd_prog), .mem_rd_addr_q(rd_addr),
        .mem_rd_data(rd_data), .mem_wr_q(wr), .mem_wr_addr_q(wr_addr),
        .mem_wr_data_q(wr_data), .done_q(done));

    dbc_mem_model mem (
        .ref_clk(ref_clk), .rst(rst), .mem_rd_q(rd),
        .mem_rd_prog_q(rd_prog), .mem_rd_addr_q(rd_addr),
        .mem_rd_data(rd_data));

    task automatic test_done();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask

    // present one command, drop valid at the accepting edge, wait done
    task automatic issue(input dbc_op_t op, input logic [15:0] opd,
                         input logic [15:0] d, input logic [7:0] cnt);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, opd, d, cnt};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        cycles = 16'h0000;
        while (done !== 1'b1 && cycles < 16'h0040) begin
            @(posedge ref_clk);
            #1;
            cycles++;
        end
        chk1(done, 1'b1);
    endtask

    // run a conditional branch once taken, once not taken
    task automatic cond(input dbc_op_t op);
        logic [15:0]             tgt;
        logic [ACC_W-1:0]        a;
        dbc_flags_t              f;
        logic                    p;
        logic [AUX_N*DATA_W-1:0] x;
        for (int t = 0; t < 2; t++) begin
            tgt = {8'h0a, 3'h0, op};
            a = '0;
            f = '0;
            p = 1'b1;
            x = {AUX_N{16'hffff}};
            case (op)
                OP_BR_AUX_NZ:    x[95:80] = t ? 16'h0001 : 16'h0000;
                OP_BR_TC_SET:    f.tc = t[0];
                OP_BR_TC_CLR:    f.tc = !t[0];
                OP_BR_CARRY:     f.carry = t[0];
                OP_BR_NO_CARRY:  f.carry = !t[0];
                OP_BR_NO_OVF:    f.ovf = !t[0];
                OP_BR_ON_OVF:    f.ovf = t[0];
                OP_BR_INPUT_LOW: p = !t[0];
                OP_BR_ACC_GE:    a = t ? 32'h0000_0000 : 32'hffff_ffff;
                OP_BR_ACC_GT:    a = t ? 32'h0000_0001 : 32'h0000_0000;
                OP_BR_ACC_LE:    a = t ? 32'h0000_0000 : 32'h0000_0001;
                OP_BR_ACC_LT:    a = t ? 32'h8000_0000 : 32'h0000_0000;
                OP_BR_ACC_EQ:    a = t ? 32'h0000_0000 : 32'h0001_0000;
                OP_BR_ACC_NE:    a = t ? 32'h0001_0000 : 32'h0000_0000;
                default:         a = '0;
            endcase
            // each input is driven once, all on the same edge
            @(posedge ref_clk);
            acc <= a;
            flags <= f;
            pin <= p;
            aux <= x;
            ptr <= 3'h5;
            repeat (6) @(posedge ref_clk);
            issue(op, tgt, 16'h0000, 8'h00);
            epc = t ? tgt : epc + STEP_TWO;
            chk16(pc, epc); // to
        end
    endtask

    // block move, source words come back from the memory model
    task automatic move(input dbc_op_t op, input logic [7:0] cnt);
        n_rd = 16'h0000;
        n_wr = 16'h0000;
        issue(op, src, dst, cnt);
        chk16(cycles, 16'({cnt, 1'b0}) + 16'h0002);
        // let the monitor count the last write before checking the total
        @(posedge ref_clk);
        #1;
        chk16(n_wr, 16'(cnt) + 16'h0001);
        epc = epc + STEP_TWO;
        chk16(pc, epc);
    endtask

    always @(posedge ref_clk) begin
        if (!rst && rd) begin
            chk16(rd_addr, src + n_rd);
            chk1(rd_prog, prog);
            chk1(ready, 1'b0);
            n_rd++;
        end
        if (!rst && wr) begin
            chk16(wr_addr, dst + n_wr);
            chk16(wr_data, prog ? ((src + n_wr) ^ 16'hc3c3)
                                : (src + n_wr + 16'h7000));
            n_wr++;
        end
        tick++;
        if (tick == 20000) begin
            n_errors++;
            $display("unexpected t=%0t timeout tick=%h limit=%h", $time,
                     tick, 20000);
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk16(pc, PC_RESET);
        chk1(ready, 1'b1);
        issue(OP_BR_ALWAYS, 16'h0100, 16'h0000, 8'h00);
        chk16(pc, 16'h0100);
        issue(OP_NOP, 16'h0000, 16'h0000, 8'h00);
        chk16(pc, 16'h0101);
        @(posedge ref_clk);
        acc <= 32'h1234_abcd;
        issue(OP_BR_TO_ACC, 16'h0000, 16'h0000, 8'h00);
        chk16(pc, 16'habcd);
        epc = 16'habcd;
        cond(OP_BR_AUX_NZ);
        cond(OP_BR_TC_SET);
        cond(OP_BR_TC_CLR);
        cond(OP_BR_CARRY);
        cond(OP_BR_NO_CARRY);
        cond(OP_BR_ACC_GE);
        cond(OP_BR_ACC_GT);
        cond(OP_BR_ACC_LE);
        cond(OP_BR_ACC_LT);
        cond(OP_BR_ACC_EQ);
        cond(OP_BR_ACC_NE);
        cond(OP_BR_INPUT_LOW);
        cond(OP_BR_NO_OVF);
        cond(OP_BR_ON_OVF);
        issue(OP_CALL_DIRECT, 16'h0400, 16'h0000, 8'h00);
        chk1(push, 1'b1);
        chk16(push_data, epc + STEP_TWO);
        chk16(pc, 16'h0400);
        @(posedge ref_clk);
        acc <= 32'hffff_0800;
        stk <= 16'h4321;
        issue(OP_CALL_INDIRECT, 16'h0000, 16'h0000, 8'h00);
        chk1(push, 1'b1);
        chk16(push_data, 16'h0401);
        chk16(pc, 16'h0800);
        issue(OP_RETURN, 16'h0000, 16'h0000, 8'h00);
        chk1(pop, 1'b1);
        chk16(pc, 16'h4321);
        epc = 16'h4321;
        src = 16'h0040;
        dst = 16'h0200;
        move(OP_MOVE_DATA, 8'h02);
        prog = 1'b1;
        src = 16'hfffe;
        dst = 16'h0300;
        move(OP_MOVE_PROG, 8'h00);
        move(OP_MOVE_PROG, 8'h03);
        test_done();
    end
endmodule
`default_nettype wire
